/* rtl/gp_regs.svh */
// Purpose: register offsets, field positions and reset values of the gpio block
// Assumes: byte addresses on an 8-bit register address, one 32-bit word each
// Notes:   port 1 words sit one stride above port 0 words
`ifndef GP_REGS_SVH
`define GP_REGS_SVH
`define GP_DIR0     8'h00
`define GP_MASK0    8'h08
`define GP_PIN0     8'h10
`define GP_MPIN0    8'h18
`define GP_SET0     8'h20
`define GP_CLR0     8'h28
`define GP_NOT0     8'h30
`define GP_PSTRIDE  8'h04
`define GP_PSEL_LO  8'h40
`define GP_PSEL_HI  8'h44
`define GP_PMODE    8'h48
`define GP_RISE     8'h4C
`define GP_FALL     8'h50
`define GP_PMSRC    8'h54
`define GP_PMCFG    8'h58
`define GP_PMCTL    8'h5C
`define GP_GCTL0    8'h60
`define GP_GPOL0    8'h64
`define GP_GENA0    8'h6C
`define GP_GSTRIDE  8'h20
`define GP_MODE_LVL 0
`define GP_MODE_ENR 8
`define GP_MODE_ENF 16
`define GP_PMC_ENA  8
`define GP_PMC_EV   9
`define GP_GC_FLAG  0
`define GP_GC_AND   1
`define GP_GC_LVL   2
`define GP_SEL_W    6
`define GP_RST_ZERO 1'b0
`endif

/* rtl/gp_pkg.sv */
// Purpose: types shared by the gpio block and its bench
// Assumes: nothing beyond the register header
// Notes:   bus request travels as one packed struct
package gp_pkg;
  typedef enum logic [1:0] {
    GP_ACTIVE = 2'b00,
    GP_SLEEP  = 2'b01,
    GP_DEEP   = 2'b10,
    GP_PDOWN  = 2'b11
  } gp_pwr_type;

  typedef enum logic [2:0] {
    GP_C_ONE  = 3'h0,
    GP_C_RISE = 3'h1,
    GP_C_FALL = 3'h2,
    GP_C_EDGE = 3'h3,
    GP_C_HIGH = 3'h4,
    GP_C_LOW  = 3'h5,
    GP_C_ZERO = 3'h6,
    GP_C_EVT  = 3'h7
  } gp_cond_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        we;
    logic        re;
  } gp_bus_type;
endpackage

/* rtl/gp_gpio.sv */
// Function
// - two ports, 0 and 1, of 32 pins each, 64 pins in all
// - every pin direction is software programmable at any time
// - set and clear writes change only the chosen output bits
// - pin read returns the synchronised pad level regardless of function
// - per-port mask limits masked reads and writes to unmasked bits
// - byte, half-word and word writes touch only enabled lanes
// - one full-word pin write updates the whole output word of a port
// - set, clear, toggle act per bit; zeros do nothing
// - all pins are inputs after reset
// - any pin can feed an edge or level interrupt
// - two group units raise requests on programmed pin combinations
// - group requests wake from sleep, deep-sleep and power-down
// - eight selectable channels, each with its own interrupt line
// - edge channels fire on rising, falling or both edges
// - level channels assert while pin high or low per polarity
// - pin interrupts wake from sleep and deep-sleep
// - pattern engine evaluates level or transition terms over eight channels
// - each product term drives its own interrupt line
// - any match optionally pulses the cpu event output
// - pattern matches wake only in active and sleep states
// - channel and group inputs read any pad regardless of function
// - from the first clock edge in power-down all pin outputs are forced to zero
//
// Purpose: gpio ports with pin interrupts, pattern match and group interrupts
// Assumes: bus and pwr_state_i come from clk_i logic; pads are asynchronous
// Notes:   reads answer in the cycle after the read strobe only
`timescale 1ns/1ps
`include "gp_regs.svh"
module gp_gpio
  import gp_pkg::*;
(
  input  logic        clk_i,
  input  logic        rst_i,
  input  gp_bus_type  bus_i,
  output logic [31:0] rdata_o,
  input  gp_pwr_type  pwr_state_i,
  input  logic [63:0] pad_i,
  output logic [63:0] pad_out_o,
  output logic [63:0] pad_oe_o,
  output logic [7:0]  pint_irq_o,
  output logic [1:0]  grp_irq_o,
  output logic        cpu_event_signal_o,
  output logic        wake_o
);
  localparam int PW   = 32;
  localparam int NPIN = 2 * PW;
  localparam int NCH  = 8;
  localparam int NGRP = 2;

  function automatic logic [31:0] bmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
    for (int b = 0; b < 4; b++) begin
      bmerge[8*b+:8] = be[b] ? wd[8*b+:8] : old[8*b+:8];
    end
  endfunction

  function automatic logic pm_term(input gp_cond_type c,
                                   input logic r,
                                   input logic f,
                                   input logic v,
                                   input logic e);
    unique case (c)
      GP_C_ONE:  pm_term = 1'b1;
      GP_C_RISE: pm_term = r;
      GP_C_FALL: pm_term = f;
      GP_C_EDGE: pm_term = r | f;
      GP_C_HIGH: pm_term = v;
      GP_C_LOW:  pm_term = ~v;
      GP_C_ZERO: pm_term = 1'b0;
      GP_C_EVT:  pm_term = e;
    endcase
  endfunction

  // pad synchroniser and edge history
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] pv_q;

  // port state
  logic [NPIN-1:0] dir_q;
  logic [NPIN-1:0] dir_d;
  logic [NPIN-1:0] mask_q;
  logic [NPIN-1:0] mask_d;
  logic [NPIN-1:0] out_q;
  logic [NPIN-1:0] out_d;
  logic [NPIN-1:0] pad_q;

  // pin interrupt and pattern state
  logic [63:0]     psel_q;
  logic [63:0]     psel_d;
  logic [23:0]     pmode_q;
  logic [23:0]     pmode_d;
  logic [NCH-1:0]  rdet_q;
  logic [NCH-1:0]  rdet_d;
  logic [NCH-1:0]  fdet_q;
  logic [NCH-1:0]  fdet_d;
  logic [23:0]     pmsrc_q;
  logic [23:0]     pmsrc_d;
  logic [23:0]     pmcfg_q;
  logic [23:0]     pmcfg_d;
  logic [9:0]      pmctl_q;
  logic [9:0]      pmctl_d;
  logic [NCH-1:0]  irq_q;
  logic            mprev_q;
  logic            ev_q;
  logic            wake_q;
  logic [31:0]     rdata_q;

  // group state
  logic [NGRP-1:0][NPIN-1:0] gpol_q;
  logic [NGRP-1:0][NPIN-1:0] gpol_d;
  logic [NGRP-1:0][NPIN-1:0] gena_q;
  logic [NGRP-1:0][NPIN-1:0] gena_d;
  logic [NGRP-1:0]           gand_q;
  logic [NGRP-1:0]           gand_d;
  logic [NGRP-1:0]           glvl_q;
  logic [NGRP-1:0]           glvl_d;
  logic [NGRP-1:0]           gflag_q;
  logic [NGRP-1:0]           gflag_d;
  logic [NGRP-1:0]           gcomb_q;
  logic [NGRP-1:0]           gcomb;
  logic [NGRP-1:0]           graw;
  logic [NGRP-1:0]           grp_q;
  logic [NGRP-1:0][31:0]     rd_grp;

  // bus decode
  logic [7:0]      a;
  logic [31:0]     wd;
  logic [3:0]      be;
  logic            wr;
  logic [31:0]     lm;
  logic [31:0]     wdm;
  logic [1:0][31:0] rd_port;

  assign a   = bus_i.addr;
  assign wd  = bus_i.wdata;
  assign be  = bus_i.be;
  assign wr  = bus_i.we;
  assign lm  = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  assign wdm = wd & lm;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      pv_q <= '0;
    end else begin
      s1_q <= pad_i;
      s2_q <= s1_q;
      pv_q <= s2_q;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam logic [7:0] OFS = (p == 0) ? 8'h00 : `GP_PSTRIDE;
    logic [31:0] cur;
    logic [31:0] msk;
    logic [31:0] keep;
    logic [31:0] lvl;
    logic        at_dir;
    logic        at_msk;
    logic        at_pin;
    logic        at_mpin;
    logic        at_set;
    logic        at_clr;
    logic        at_not;
    assign cur     = out_q[PW*p+:PW];
    assign msk     = mask_q[PW*p+:PW];
    assign lvl     = s2_q[PW*p+:PW];
    assign keep    = lm & ~msk;
    assign at_dir  = a == (`GP_DIR0 + OFS);
    assign at_msk  = a == (`GP_MASK0 + OFS);
    assign at_pin  = a == (`GP_PIN0 + OFS);
    assign at_mpin = a == (`GP_MPIN0 + OFS);
    assign at_set  = a == (`GP_SET0 + OFS);
    assign at_clr  = a == (`GP_CLR0 + OFS);
    assign at_not  = a == (`GP_NOT0 + OFS);
    assign dir_d[PW*p+:PW]  = (wr && at_dir) ? bmerge(dir_q[PW*p+:PW], wd, be)
                                             : dir_q[PW*p+:PW];
    assign mask_d[PW*p+:PW] = (wr && at_msk) ? bmerge(msk, wd, be) : msk;
    assign out_d[PW*p+:PW] =
      (wr && at_pin)  ? bmerge(cur, wd, be) :
      (wr && at_mpin) ? (cur & ~keep) | (wd & keep) :
      (wr && at_set)  ? cur | wdm :
      (wr && at_clr)  ? cur & ~wdm :
      (wr && at_not)  ? cur ^ wdm : cur;
    // set, clear and toggle words are write-only and read zero
    assign rd_port[p] = ({32{at_dir}}  & dir_q[PW*p+:PW]) |
                        ({32{at_msk}}  & msk) |
                        ({32{at_pin}}  & lvl) |
                        ({32{at_mpin}} & lvl & ~msk);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_q  <= {NPIN{`GP_RST_ZERO}};
      mask_q <= {NPIN{`GP_RST_ZERO}};
      out_q  <= {NPIN{`GP_RST_ZERO}};
      pad_q  <= {NPIN{`GP_RST_ZERO}};
    end else begin
      dir_q  <= dir_d;
      mask_q <= mask_d;
      out_q  <= out_d;
      pad_q  <= (pwr_state_i == GP_PDOWN) ? '0 : out_d;
    end
  end

  // pin interrupt and pattern registers
  logic        at_psl;
  logic        at_psh;
  logic        at_pmd;
  logic        at_rise;
  logic        at_fall;
  logic        at_pms;
  logic        at_pmf;
  logic        at_pmc;
  logic [31:0] pmode_m;
  logic [31:0] pmsrc_m;
  logic [31:0] pmcfg_m;
  logic [31:0] pmctl_m;
  logic [7:0]  clr_r;
  logic [7:0]  clr_f;
  assign at_psl  = a == `GP_PSEL_LO;
  assign at_psh  = a == `GP_PSEL_HI;
  assign at_pmd  = a == `GP_PMODE;
  assign at_rise = a == `GP_RISE;
  assign at_fall = a == `GP_FALL;
  assign at_pms  = a == `GP_PMSRC;
  assign at_pmf  = a == `GP_PMCFG;
  assign at_pmc  = a == `GP_PMCTL;
  assign pmode_m = bmerge({8'h00, pmode_q}, wd, be);
  assign pmsrc_m = bmerge({8'h00, pmsrc_q}, wd, be);
  assign pmcfg_m = bmerge({8'h00, pmcfg_q}, wd, be);
  assign pmctl_m = bmerge({22'h000000, pmctl_q}, wd, be);
  assign psel_d[31:0]  = (wr && at_psl) ? bmerge(psel_q[31:0], wd, be) : psel_q[31:0];
  assign psel_d[63:32] = (wr && at_psh) ? bmerge(psel_q[63:32], wd, be) : psel_q[63:32];
  assign pmode_d = (wr && at_pmd) ? pmode_m[23:0] : pmode_q;
  assign pmsrc_d = (wr && at_pms) ? pmsrc_m[23:0] : pmsrc_q;
  assign pmcfg_d = (wr && at_pmf) ? pmcfg_m[23:0] : pmcfg_q;
  assign pmctl_d = (wr && at_pmc) ? pmctl_m[9:0] : pmctl_q;
  // write one to clear; a new edge in the same cycle still sets
  assign clr_r = (wr && at_rise) ? wdm[7:0] : 8'h00;
  assign clr_f = (wr && at_fall) ? wdm[7:0] : 8'h00;

  // channel front end
  logic [NCH-1:0] ch_v;
  logic [NCH-1:0] ch_r;
  logic [NCH-1:0] ch_f;
  logic [NCH-1:0] pint_raw;
  logic [NCH-1:0] term;
  logic [NCH-1:0] acc;
  logic [NCH-1:0] endp;
  logic [NCH-1:0] match;
  logic           pm_on;
  logic           ev_on;
  assign pm_on = pmctl_q[`GP_PMC_ENA];
  assign ev_on = pmctl_q[`GP_PMC_EV];
  // last slice always closes a product term
  assign endp  = {1'b1, pmctl_q[NCH-2:0]};

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [`GP_SEL_W-1:0] sel;
    logic [2:0]           src;
    logic                 isl;
    logic                 enr;
    logic                 enf;
    assign sel  = psel_q[8*c+:`GP_SEL_W];
    assign ch_v[c] = s2_q[sel];
    assign ch_r[c] = s2_q[sel] & ~pv_q[sel];
    assign ch_f[c] = ~s2_q[sel] & pv_q[sel];
    assign isl  = pmode_q[`GP_MODE_LVL + c];
    assign enr  = pmode_q[`GP_MODE_ENR + c];
    assign enf  = pmode_q[`GP_MODE_ENF + c];
    assign rdet_d[c] = (rdet_q[c] & ~clr_r[c]) | ch_r[c];
    assign fdet_d[c] = (fdet_q[c] & ~clr_f[c]) | ch_f[c];
    // level mode: enr enables, enf picks high-active polarity
    assign pint_raw[c] = isl ? (enr & ~(ch_v[c] ^ enf))
                             : ((rdet_q[c] & enr) | (fdet_q[c] & enf));
    assign src  = pmsrc_q[3*c+:3];
    assign term[c] = pm_term(gp_cond_type'(pmcfg_q[3*c+:3]), rdet_q[src],
                             fdet_q[src], ch_v[src], ch_r[src] | ch_f[src]);
    if (c == 0) begin : g_first
      assign acc[c] = term[c];
    end else begin : g_next
      assign acc[c] = term[c] & (endp[c-1] | acc[c-1]);
    end
    assign match[c] = endp[c] & acc[c];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      psel_q  <= '0;
      pmode_q <= '0;
      rdet_q  <= '0;
      fdet_q  <= '0;
      pmsrc_q <= '0;
      pmcfg_q <= '0;
      pmctl_q <= '0;
    end else begin
      psel_q  <= psel_d;
      pmode_q <= pmode_d;
      rdet_q  <= rdet_d;
      fdet_q  <= fdet_d;
      pmsrc_q <= pmsrc_d;
      pmcfg_q <= pmcfg_d;
      pmctl_q <= pmctl_d;
    end
  end

  // group interrupt units
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    localparam logic [7:0] GB = (g == 0) ? 8'h00 : `GP_GSTRIDE;
    logic [NPIN-1:0] act;
    logic [31:0]     ctl_m;
    logic            at_ctl;
    logic            at_p0;
    logic            at_p1;
    logic            at_e0;
    logic            at_e1;
    logic            clr;
    assign at_ctl = a == (`GP_GCTL0 + GB);
    assign at_p0  = a == (`GP_GPOL0 + GB);
    assign at_p1  = a == (`GP_GPOL0 + GB + `GP_PSTRIDE);
    assign at_e0  = a == (`GP_GENA0 + GB);
    assign at_e1  = a == (`GP_GENA0 + GB + `GP_PSTRIDE);
    assign gpol_d[g][31:0]  = (wr && at_p0) ? bmerge(gpol_q[g][31:0], wd, be)
                                            : gpol_q[g][31:0];
    assign gpol_d[g][63:32] = (wr && at_p1) ? bmerge(gpol_q[g][63:32], wd, be)
                                            : gpol_q[g][63:32];
    assign gena_d[g][31:0]  = (wr && at_e0) ? bmerge(gena_q[g][31:0], wd, be)
                                            : gena_q[g][31:0];
    assign gena_d[g][63:32] = (wr && at_e1) ? bmerge(gena_q[g][63:32], wd, be)
                                            : gena_q[g][63:32];
    assign ctl_m  = {29'h00000000, glvl_q[g], gand_q[g], gflag_q[g]};
    assign gand_d[g] = (wr && at_ctl && be[0]) ? wd[`GP_GC_AND] : gand_q[g];
    assign glvl_d[g] = (wr && at_ctl && be[0]) ? wd[`GP_GC_LVL] : glvl_q[g];
    assign clr    = wr && at_ctl && wdm[`GP_GC_FLAG];
    // polarity one means the pin is active while high
    assign act    = gena_q[g] & ~(s2_q ^ gpol_q[g]);
    assign gcomb[g] = gand_q[g] ? (|gena_q[g] & &(act | ~gena_q[g]))
                                : |act;
    // set wins over the write-one clear
    assign gflag_d[g] = (gflag_q[g] & ~clr) | (gcomb[g] & ~gcomb_q[g]) |
                        (glvl_q[g] & gcomb[g]);
    assign graw[g]   = glvl_q[g] ? gcomb[g] : gflag_q[g];
    assign rd_grp[g] = ({32{at_ctl}} & ctl_m) |
                       ({32{at_p0}} & gpol_q[g][31:0]) |
                       ({32{at_p1}} & gpol_q[g][63:32]) |
                       ({32{at_e0}} & gena_q[g][31:0]) |
                       ({32{at_e1}} & gena_q[g][63:32]);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gpol_q  <= '0;
      gena_q  <= '0;
      gand_q  <= '0;
      glvl_q  <= '0;
      gflag_q <= '0;
      gcomb_q <= '0;
    end else begin
      gpol_q  <= gpol_d;
      gena_q  <= gena_d;
      gand_q  <= gand_d;
      glvl_q  <= glvl_d;
      gflag_q <= gflag_d;
      gcomb_q <= gcomb;
    end
  end

  // interrupt, event and wake outputs
  logic        any_m;
  logic        lite;
  logic        wake_d;
  logic [31:0] rd_glob;
  logic [31:0] rd_all;
  assign any_m  = |match;
  assign lite   = (pwr_state_i == GP_ACTIVE) || (pwr_state_i == GP_SLEEP);
  // pattern wake is barred below sleep because its clock may be gone there
  assign wake_d = (pm_on ? (any_m & lite)
                         : (|pint_raw & (pwr_state_i != GP_PDOWN))) |
                  (|graw);

  assign rd_glob = ({32{at_psl}}  & psel_q[31:0]) |
                   ({32{at_psh}}  & psel_q[63:32]) |
                   ({32{at_pmd}}  & {8'h00, pmode_q}) |
                   ({32{at_rise}} & {24'h000000, rdet_q}) |
                   ({32{at_fall}} & {24'h000000, fdet_q}) |
                   ({32{at_pms}}  & {8'h00, pmsrc_q}) |
                   ({32{at_pmf}}  & {8'h00, pmcfg_q}) |
                   ({32{at_pmc}}  & {match, 14'h0000, pmctl_q});
  // unmapped addresses read zero
  assign rd_all = rd_glob | rd_port[0] | rd_port[1] | rd_grp[0] | rd_grp[1];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q   <= '0;
      grp_q   <= '0;
      mprev_q <= 1'b0;
      ev_q    <= 1'b0;
      wake_q  <= 1'b0;
      rdata_q <= '0;
    end else begin
      irq_q   <= pm_on ? match : pint_raw;
      grp_q   <= graw;
      mprev_q <= any_m;
      ev_q    <= ev_on & any_m & ~mprev_q;
      wake_q  <= wake_d;
      rdata_q <= bus_i.re ? rd_all : '0;
    end
  end

  assign rdata_o            = rdata_q;
  assign pad_out_o          = pad_q;
  assign pad_oe_o           = dir_q;
  assign pint_irq_o         = irq_q;
  assign grp_irq_o          = grp_q;
  assign cpu_event_signal_o = ev_q;
  assign wake_o             = wake_q;
endmodule // gp_gpio

/* verif/gp_gpio_checker.sv */
// Purpose: port-level checks of gp_gpio
// Assumes: one clock, reset active high
// Notes:   set, clear and word-write checks skip edges next to power-down
`timescale 1ns/1ps
`include "gp_regs.svh"
module gp_gpio_checker
  import gp_pkg::*;
(
  input logic        clk_i,
  input logic        rst_i,
  input gp_bus_type  bus_i,
  input logic [31:0] rdata_o,
  input gp_pwr_type  pwr_state_i,
  input logic [63:0] pad_out_o,
  input logic [63:0] pad_oe_o,
  input logic        cpu_event_signal_o
);
  wire [31:0] lm = {{8{bus_i.be[3]}}, {8{bus_i.be[2]}}, {8{bus_i.be[1]}}, {8{bus_i.be[0]}}};
  wire [31:0] wb = lm & bus_i.wdata;
  wire        up = pwr_state_i != GP_PDOWN;
  wire        wr = bus_i.we && up;
  wire [31:0] po = pad_out_o[31:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // power-down hides the output register, so both edges must be awake
  chk_set_bits: assert property ((wr && bus_i.addr == `GP_SET0 && $past(up)) ##1 up
    |-> po == ($past(po) | $past(wb))) else $error("set write wrong");
  chk_clr_bits: assert property ((wr && bus_i.addr == `GP_CLR0 && $past(up)) ##1 up
    |-> po == ($past(po) & ~$past(wb))) else $error("clear write wrong");
  chk_word_write: assert property ((wr && bus_i.addr == `GP_PIN0 && $past(up)) ##1 up
    |-> po == (($past(po) & ~$past(lm)) | $past(wb))) else $error("word write wrong");
  chk_dir_lanes: assert property (bus_i.we && bus_i.addr == `GP_DIR0 + `GP_PSTRIDE
    |=> pad_oe_o[63:32] == (($past(pad_oe_o[63:32]) & ~$past(lm)) | $past(wb)))
    else $error("direction write wrong");
  chk_pdown_zero: assert property ((pwr_state_i == GP_PDOWN)[*2] |-> pad_out_o == 64'h0)
    else $error("outputs live in power-down");
  chk_reset_input: assert property ($fell(rst_i) |-> pad_oe_o == 64'h0)
    else $error("pin driven after reset");
  chk_rdata_idle: assert property (!$past(bus_i.re) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
  chk_event_pulse: assert property (cpu_event_signal_o |=> !cpu_event_signal_o)
    else $error("event longer than one cycle");
endmodule // gp_gpio_checker

bind gp_gpio gp_gpio_checker chk (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .pwr_state_i(pwr_state_i), .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o), .cpu_event_signal_o(cpu_event_signal_o));

/* verif/gp_pad_board.sv */
// Purpose: board side of the gpio pads
// Assumes: every pad has a pull-down
// Notes:   contention between chip and board is not modelled
`timescale 1ns/1ps
module gp_pad_board #(
  parameter int DLY_NS = 3
) (
  input  logic [63:0] pad_out_i,
  input  logic [63:0] pad_oe_i,
  input  logic [63:0] ext_val_i,
  input  logic [63:0] ext_en_i,
  output logic [63:0] pad_o
);
  // released pads fall to the pull-down instead of holding the last level
  assign #(DLY_NS) pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i);
endmodule // gp_pad_board

/* verif/tb.sv */
// Purpose: directed register-port test of gp_gpio
// Assumes: gp_pad_board closes the pad loop; the bench drives port 1
// Notes:   pins 40 and 41 carry the interrupt tests
`timescale 1ns/1ps
`include "gp_regs.svh"
module tb
  import gp_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  gp_bus_type  bus;
  gp_pwr_type  pwr;
  logic [31:0] rdata;
  logic [63:0] pad, pout, poe, ext_val;
  logic [7:0]  pirq;
  logic [1:0]  girq;
  logic        ev;
  logic        wake;
  int          err_total;
  int          comparisons;

  gp_gpio uut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .pwr_state_i(pwr),
    .pad_i(pad), .pad_out_o(pout), .pad_oe_o(poe), .pint_irq_o(pirq), .grp_irq_o(girq),
    .cpu_event_signal_o(ev), .wake_o(wake));
  gp_pad_board board (.pad_out_i(pout), .pad_oe_i(poe), .ext_val_i(ext_val),
    .ext_en_i(64'hFFFFFFFF_00000000), .pad_o(pad));

  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, be: b, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    bus.we <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 32'h0, be: 4'hF, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    bus.re <= 1'b0;
    #1;
    cmp("rdata", {32'h0, e}, {32'h0, rdata});
  endtask

  task automatic wait_sig(input int sel, input logic v);
    logic  s;
    string nm;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_i);
      #1;
      s = sel == 0 ? pirq[0] : sel == 1 ? girq[0] : sel == 2 ? girq[1] : sel == 3 ? ev : wake;
      if (s === v) begin
        comparisons++;
        return;
      end
    end
    err_total++;
    nm = sel == 0 ? "pint_irq" : sel == 1 ? "grp_irq0" : sel == 2 ? "grp_irq1" :
         sel == 3 ? "cpu_event" : "wake";
    $display("[ERR] %s expected %b seen %b", nm, v, s);
    report_and_stop();
  endtask

  // both flags cleared each time, so a wrong-edge fire cannot linger
  task automatic edge_hit(input logic [31:0] mode, input logic v);
    wr(`GP_PMODE, mode, 4'hF);
    @(posedge clk_i);
    ext_val[40] <= v;
    wait_sig(0, 1'b1);
    wr(`GP_RISE, 32'h00000001, 4'hF);
    wr(`GP_FALL, 32'h00000001, 4'hF);
    wait_sig(0, 1'b0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    bus = '0;
    pwr = GP_ACTIVE;
    ext_val = 64'h0;
    err_total = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    cmp("oe", 64'h0, poe);
    rd(`GP_DIR0 + `GP_PSTRIDE, 32'h0);
    wr(`GP_DIR0, 32'hFFFFFFFF, 4'hF);
    wr(`GP_PIN0, 32'h12345678, 4'hF);
    cmp("out", 64'h12345678, pout);
    repeat (3) @(posedge clk_i);
    rd(`GP_PIN0, 32'h12345678);
    wr(`GP_SET0, 32'hFFFFFFFF, 4'h1);
    cmp("out", 64'h123456FF, pout);
    wr(`GP_CLR0, 32'h000000F0, 4'hF);
    cmp("out", 64'h1234560F, pout);
    wr(`GP_NOT0, 32'hFF00FF00, 4'hF);
    cmp("out", 64'hED34A90F, pout);
    wr(`GP_MASK0, 32'hFFFF0000, 4'hF);
    wr(`GP_MPIN0, 32'h55551234, 4'hF);
    cmp("out", 64'hED341234, pout);
    repeat (3) @(posedge clk_i);
    rd(`GP_MPIN0, 32'h00001234);
    rd(`GP_SET0, 32'h0);
    rd(8'hFC, 32'h0);
    wr(`GP_DIR0 + `GP_PSTRIDE, 32'hFFFFFFFF, 4'h2);
    cmp("oe", 64'h0000FF00_FFFFFFFF, poe);
    wr(`GP_DIR0 + `GP_PSTRIDE, 32'h0, 4'hF);
    @(posedge clk_i);
    ext_val <= 64'h00A50000_00000000;
    rd(`GP_PIN0 + `GP_PSTRIDE, 32'h0);
    repeat (3) @(posedge clk_i);
    rd(`GP_PIN0 + `GP_PSTRIDE, 32'h00A50000);
    wr(`GP_PSEL_LO, 32'h00000028, 4'h1);
    wr(`GP_RISE, 32'h000000FF, 4'hF);
    wr(`GP_FALL, 32'h000000FF, 4'hF);
    edge_hit(32'h00000100, 1'b1);
    edge_hit(32'h00010000, 1'b0);
    edge_hit(32'h00010100, 1'b1);
    edge_hit(32'h00010100, 1'b0);
    wr(`GP_PMODE, 32'h00010101, 4'hF);
    repeat (4) @(posedge clk_i);
    #1;
    cmp("irq", 64'h0, {56'h0, pirq});
    @(posedge clk_i);
    ext_val[40] <= 1'b1;
    wait_sig(0, 1'b1);
    @(posedge clk_i);
    pwr <= GP_SLEEP;
    wait_sig(4, 1'b1);
    @(posedge clk_i);
    pwr <= GP_PDOWN;
    wait_sig(4, 1'b0);
    cmp("out", 64'h0, pout);
    wr(`GP_PMODE, 32'h00000101, 4'hF);
    wait_sig(0, 1'b0);
    wr(`GP_GENA0 + 8'h04, 32'h00000100, 4'hF);
    wr(`GP_GPOL0 + 8'h04, 32'h00000100, 4'hF);
    wr(`GP_GCTL0, 32'h00000004, 4'hF);
    wait_sig(1, 1'b1);
    wait_sig(4, 1'b1);
    wr(`GP_GENA0 + `GP_GSTRIDE + 8'h04, 32'h00000300, 4'hF);
    wr(`GP_GPOL0 + `GP_GSTRIDE + 8'h04, 32'h00000300, 4'hF);
    wr(`GP_GCTL0 + `GP_GSTRIDE, 32'h00000006, 4'hF);
    repeat (4) @(posedge clk_i);
    #1;
    cmp("grp", 64'h1, {62'h0, girq});
    @(posedge clk_i);
    ext_val[41] <= 1'b1;
    wait_sig(2, 1'b1);
    @(posedge clk_i);
    ext_val[41:40] <= 2'b00;
    wr(`GP_GENA0 + 8'h04, 32'h0, 4'hF);
    @(posedge clk_i);
    pwr <= GP_ACTIVE;
    wr(`GP_PMCFG, {8'h0, {7{3'h6}}, 3'h4}, 4'hF);
    wr(`GP_PMCTL, 32'h00000301, 4'hF);
    @(posedge clk_i);
    ext_val[40] <= 1'b1;
    wait_sig(3, 1'b1);
    wait_sig(0, 1'b1);
    cmp("irq", 64'h1, {56'h0, pirq});
    rd(`GP_PMCTL, 32'h01000301);
    @(posedge clk_i);
    pwr <= GP_DEEP;
    wait_sig(4, 1'b0);
    @(posedge clk_i);
    pwr <= GP_SLEEP;
    wait_sig(4, 1'b1);
    // transition term: one match cycle per pin edge, none while steady
    wr(`GP_PMCFG, {8'h0, {7{3'h6}}, 3'h7}, 4'hF);
    wait_sig(0, 1'b0);
    @(posedge clk_i);
    ext_val[40] <= 1'b0;
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
    // group edge mode: a rise sets the flag, a write of one clears it
    wr(`GP_GCTL0, 32'h00000001, 4'hF);
    wr(`GP_GENA0 + 8'h04, 32'h00000100, 4'hF);
    wait_sig(1, 1'b0);
    @(posedge clk_i);
    ext_val[40] <= 1'b1;
    wait_sig(1, 1'b1);
    wr(`GP_GCTL0, 32'h00000001, 4'hF);
    wait_sig(1, 1'b0);
    report_and_stop();
  end
endmodule // tb
